// [include/timer_b_pkg.sv]
// timer_b_pkg: constants and carrier types for the second timer block
// assumes a single 125 MHz timer clock and active-low async reset
`default_nettype none
package timer_b_pkg;
  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          PER_CYCLE_CLKS = 6;   // timer clock periods per peripheral cycle
  localparam int          SYNC_STAGES    = 3;
  localparam logic [1:0]  MODE_13BIT     = 2'h0;
  localparam logic [1:0]  MODE_16BIT     = 2'h1;
  localparam logic [1:0]  MODE_RELOAD    = 2'h2;
  localparam logic [1:0]  MODE_HALT      = 2'h3;
  localparam logic [4:0]  PRESCALE_TOP   = 5'h1F;
  localparam logic [7:0]  BYTE_TOP       = 8'hFF;
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  localparam int          DIV_SEL_BITS   = 3;
  localparam int          DIV_CNT_BITS   = 7;   // divisor up to 128
  localparam int          PIN_GATE       = 0;
  localparam int          PIN_COUNT      = 1;

  // upper nibble of the mode register, bit 7 first
  typedef struct packed {
    logic       timer_b_gating;
    logic       timer_b_count_source;
    logic       timer_b_mode_hi;
    logic       timer_b_mode_lo;
  } timer_b_cfg_t;

  // software preset path for the count bytes
  typedef struct packed {
    logic       low_wr;
    logic       high_wr;
    logic [7:0] data;
  } count_wr_t;

  typedef struct packed {
    logic       timer_irq_enable_a;
    logic       timer_irq_enable_b;
    logic       global_irq_enable;
  } irq_enable_reg_t;
endpackage
`default_nettype wire

// [verilog/timer_b_core.sv]
// timer_b_core: second timer/counter, first timer overflow divider, irq gating
// assumes timer-a logic on ref_clk supplies its overflow pulses and split-mode state
`timescale 1ns/10ps
`default_nettype none

module timer_b_core #(
  parameter int DIV_SEL_W = timer_b_pkg::DIV_SEL_BITS,
  parameter int DIV_CNT_W = timer_b_pkg::DIV_CNT_BITS
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_b,
  input  wire timer_b_pkg::timer_b_cfg_t    timer_mode_hi,
  input  wire logic                         timer_b_run,
  input  wire logic                         ext_irq_b_trigger_type,
  input  wire logic                         ext_irq_b_ack,
  input  wire timer_b_pkg::count_wr_t       count_wr,
  input  wire logic                         ext_gate_pin_b,
  input  wire logic                         timer_b_count_pin,
  input  wire logic                         timer_a_split,
  input  wire logic                         timer_a_ovf,
  input  wire logic                         timer_a_hi_ovf,
  input  wire logic [DIV_SEL_W-1:0]         ovf_divider_sel,
  input  wire logic                         vector_ack_a,
  input  wire logic                         vector_ack_b,
  input  wire timer_b_pkg::irq_enable_reg_t irq_enable_reg,
  output logic [7:0]                        timer_b_high_byte,
  output logic [7:0]                        timer_b_low_byte,
  output logic                              timer_b_overflow_flag,
  output logic                              timer_a_overflow_flag,
  output logic                              ext_irq_b_edge_flag,
  output logic                              timer_a_hi_run,
  output logic                              baud_tick,
  output logic                              irq_a,
  output logic                              irq_b
);
  import timer_b_pkg::*;

  function automatic logic [DIV_CNT_W-1:0] div_mask(input logic [DIV_SEL_W-1:0] sel);
    logic [DIV_CNT_W:0] one_hot;
    one_hot = '0;
    one_hot[sel] = 1'b1;
    div_mask = DIV_CNT_W'(one_hot - (DIV_CNT_W + 1)'(1));
  endfunction

  // pin synchronisers, three stages; level moves when stages two and three agree
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] sync3;
  logic [1:0] pin_lvl;
  wire  [1:0] pins = {timer_b_count_pin, ext_gate_pin_b};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          sync1[g]   <= 1'b1;
          sync2[g]   <= 1'b1;
          sync3[g]   <= 1'b1;
          pin_lvl[g] <= 1'b1;
        end else begin
          sync1[g] <= pins[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g]) begin
            pin_lvl[g] <= sync3[g];
          end
        end
      end
    end
  endgenerate

  // peripheral cycle strobe
  logic [2:0] per_cnt;
  logic       per_tick;
  logic       cnt_sample;
  wire        per_last = (per_cnt == 3'(PER_CYCLE_CLKS - 1));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      per_cnt    <= 3'h0;
      per_tick   <= 1'b0;
      cnt_sample <= 1'b1;
    end else begin
      per_cnt  <= per_last ? 3'h0 : per_cnt + 3'h1;
      per_tick <= per_last;
      if (per_tick) begin
        cnt_sample <= pin_lvl[PIN_COUNT];
      end
    end
  end

  // count event: high sample then low sample one peripheral cycle later
  wire pin_fall = per_tick && cnt_sample && !pin_lvl[PIN_COUNT];
  wire src_evt  = timer_mode_hi.timer_b_count_source ? pin_fall : per_tick;
  // in split mode the run bit belongs to timer a; only halt mode or the gate pin low with gating set stops it
  wire run_eff  = timer_a_split ? 1'b1 : timer_b_run;
  wire gate_ok  = !timer_mode_hi.timer_b_gating || pin_lvl[PIN_GATE];
  wire [1:0] mode = {timer_mode_hi.timer_b_mode_hi, timer_mode_hi.timer_b_mode_lo};
  wire inc      = src_evt && run_eff && gate_ok && (mode != MODE_HALT);

  // next count per mode
  wire       pre_wrap  = (timer_b_low_byte[4:0] == PRESCALE_TOP);
  wire       low_wrap  = (timer_b_low_byte == BYTE_TOP);
  wire       high_wrap = (timer_b_high_byte == BYTE_TOP);
  logic [7:0] next_low;
  logic [7:0] next_high;
  logic       wrap;

  always_comb begin
    next_low  = timer_b_low_byte;
    next_high = timer_b_high_byte;
    wrap      = 1'b0;
    case (mode)
      MODE_13BIT: begin
        // upper three low bits left alone
        next_low[4:0] = timer_b_low_byte[4:0] + 5'h1;
        if (pre_wrap) begin
          next_high = timer_b_high_byte + 8'h1;
          wrap      = high_wrap;
        end
      end
      MODE_16BIT: begin
        next_low = timer_b_low_byte + 8'h1;
        if (low_wrap) begin
          next_high = timer_b_high_byte + 8'h1;
          wrap      = high_wrap;
        end
      end
      MODE_RELOAD: begin
        next_low = low_wrap ? timer_b_high_byte : timer_b_low_byte + 8'h1;
        wrap     = low_wrap;
      end
      default: begin
        next_low  = timer_b_low_byte;
        next_high = timer_b_high_byte;
      end
    endcase
  end

  wire b_ovf   = inc && wrap;
  // split mode: timer-a high byte owns the flag
  wire b_set   = timer_a_split ? timer_a_hi_ovf : b_ovf;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_b_low_byte  <= BYTE_RST;
      timer_b_high_byte <= BYTE_RST;
    end else begin
      // presets win; counting while running is undefined per software contract
      if (count_wr.low_wr) begin
        timer_b_low_byte <= count_wr.data;
      end else if (inc) begin
        timer_b_low_byte <= next_low;
      end
      if (count_wr.high_wr) begin
        timer_b_high_byte <= count_wr.data;
      end else if (inc) begin
        timer_b_high_byte <= next_high;
      end
    end
  end

  // timer-a overflow divider
  logic [DIV_CNT_W-1:0] div_cnt;
  wire [DIV_CNT_W-1:0]  div_top = div_mask(ovf_divider_sel);
  wire                  div_hit = (div_cnt >= div_top);
  wire                  a_set   = timer_a_ovf && div_hit;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= '0;
    end else if (timer_a_ovf) begin
      div_cnt <= div_hit ? '0 : div_cnt + DIV_CNT_W'(1);
    end
  end

  // external interrupt b: edge or level on gate pin
  logic gate_prev;
  wire  gate_fall = gate_prev && !pin_lvl[PIN_GATE];
  wire  ext_set   = ext_irq_b_trigger_type ? gate_fall : !pin_lvl[PIN_GATE];

  // flags: set beats clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_b_overflow_flag <= 1'b0;
      timer_a_overflow_flag <= 1'b0;
      ext_irq_b_edge_flag   <= 1'b0;
      gate_prev             <= 1'b1;
      timer_a_hi_run        <= 1'b0;
      baud_tick             <= 1'b0;
      irq_a                 <= 1'b0;
      irq_b                 <= 1'b0;
    end else begin
      timer_b_overflow_flag <= b_set || (timer_b_overflow_flag && !vector_ack_b);
      timer_a_overflow_flag <= a_set || (timer_a_overflow_flag && !vector_ack_a);
      ext_irq_b_edge_flag   <= ext_set || (ext_irq_b_edge_flag && !ext_irq_b_ack);
      gate_prev             <= pin_lvl[PIN_GATE];
      timer_a_hi_run        <= timer_a_split && timer_b_run;
      baud_tick             <= b_ovf;
      irq_a <= timer_a_overflow_flag && irq_enable_reg.timer_irq_enable_a
               && irq_enable_reg.global_irq_enable;
      irq_b <= timer_b_overflow_flag && irq_enable_reg.timer_irq_enable_b
               && irq_enable_reg.global_irq_enable;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_tick_period: assert property (per_tick |-> ##6 per_tick)
    else $error("peripheral strobe not every six clocks");
  a_halt_holds: assert property ((mode == MODE_HALT && !count_wr.low_wr && !count_wr.high_wr)
    |=> $stable(timer_b_low_byte) && $stable(timer_b_high_byte))
    else $error("halt mode changed the count");
  a_ovf_flag_set: assert property ((b_ovf && !timer_a_split) |=> timer_b_overflow_flag)
    else $error("overflow did not set flag");
  a_split_owns_flag: assert property ((timer_a_split && !timer_a_hi_ovf && !timer_b_overflow_flag)
    |=> !timer_b_overflow_flag)
    else $error("timer b set flag in split mode");
  a_div_pass_all: assert property ((ovf_divider_sel == '0 && timer_a_ovf)
    |=> timer_a_overflow_flag)
    else $error("undivided overflow lost");
  a_ack_clears: assert property ((vector_ack_b && !b_set) |=> !timer_b_overflow_flag)
    else $error("vector ack did not clear flag");
  a_irq_enables: assert property (irq_b |-> $past(timer_b_overflow_flag)
    && $past(irq_enable_reg.global_irq_enable) && $past(irq_enable_reg.timer_irq_enable_b))
    else $error("irq raised without enables");
  a_reload_value: assert property ((mode == MODE_RELOAD && inc && low_wrap && !count_wr.low_wr)
    |=> timer_b_low_byte == $past(timer_b_high_byte))
    else $error("reload value wrong");
  a_gate_blocks: assert property ((timer_mode_hi.timer_b_gating && !pin_lvl[PIN_GATE]
    && !count_wr.low_wr) |=> $stable(timer_b_low_byte))
    else $error("count moved with gate low");
  a_mode0_upper: assert property ((mode == MODE_13BIT && !count_wr.low_wr)
    |=> $stable(timer_b_low_byte[7:5]))
    else $error("mode 0 touched upper low bits");

  c_reload: cover property (mode == MODE_RELOAD && b_ovf);
  c_div_max: cover property (ovf_divider_sel == 3'h7 && a_set);
  c_split_flag: cover property (timer_a_split && timer_a_hi_ovf);
  c_count_pin: cover property (timer_mode_hi.timer_b_count_source && inc);
endmodule
`default_nettype wire

// [test/pin_drive.sv]
// pin_drive: far-side model of the gate and count pins of the second timer
// assumes the bench pulses start for one clock with falls valid beside it
`timescale 1ns/10ps
`default_nettype none
module pin_drive (
  input  wire logic       ref_clk,
  input  wire logic       gate_req,
  input  wire logic       start,
  input  wire logic [2:0] falls,
  output logic            ext_gate_pin_b,
  output logic            timer_b_count_pin,
  output logic            busy
);
  assign ext_gate_pin_b = gate_req;
  // each level held two peripheral cycles so the sampler sees both
  initial begin
    timer_b_count_pin = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (start === 1'b1) begin
        busy <= 1'b1;
        repeat (falls) begin
          repeat (12) @(posedge ref_clk);
          timer_b_count_pin <= 1'b0;
          repeat (12) @(posedge ref_clk);
          timer_b_count_pin <= 1'b1;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [test/tb.sv]
// tb: self-checking bench for timer_b_core with a pin model on the far side
// assumes a pin sync latency of 3-4 clocks and 6-clock peripheral ticks
`timescale 1ns/10ps
`default_nettype none
module tb;
  import timer_b_pkg::*;
  logic            ref_clk, rst_b, run, trig, ack_e, split, a_ovf, a_hi, ack_a, ack_b;
  logic            gate, start, tfb, tfa, efb, hi_run, baud, irq_a, irq_b, cpin, gpin, busy;
  timer_b_cfg_t    cfg;
  count_wr_t       cw;
  irq_enable_reg_t en;
  logic [2:0]      sel, falls;
  logic [7:0]      hb, lb, h, l;
  logic [15:0]     was;
  int              err_total, num_checks, i, k, t;

  timer_b_core u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .timer_mode_hi(cfg),
    .timer_b_run(run), .ext_irq_b_trigger_type(trig), .ext_irq_b_ack(ack_e),
    .count_wr(cw), .ext_gate_pin_b(gpin), .timer_b_count_pin(cpin),
    .timer_a_split(split), .timer_a_ovf(a_ovf), .timer_a_hi_ovf(a_hi),
    .ovf_divider_sel(sel), .vector_ack_a(ack_a), .vector_ack_b(ack_b),
    .irq_enable_reg(en), .timer_b_high_byte(hb), .timer_b_low_byte(lb),
    .timer_b_overflow_flag(tfb), .timer_a_overflow_flag(tfa), .ext_irq_b_edge_flag(efb),
    .timer_a_hi_run(hi_run), .baud_tick(baud), .irq_a(irq_a), .irq_b(irq_b));
  pin_drive u_pins (.ref_clk(ref_clk), .gate_req(gate), .start(start), .falls(falls),
    .ext_gate_pin_b(gpin), .timer_b_count_pin(cpin), .busy(busy));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // one-cycle strobes: 0 a ovf, 1 a high ovf, 2 ack a, 3 ack b, 4 ext ack
  task automatic pulse(input int w);
    @(posedge ref_clk) {a_ovf, a_hi, ack_a, ack_b, ack_e} <= 5'h10 >> w;
    @(posedge ref_clk) {a_ovf, a_hi, ack_a, ack_b, ack_e} <= 5'h00;
  endtask
  task automatic setup(input logic g, input logic cs, input logic [1:0] m,
                       input logic [7:0] lo, input logic [7:0] hi);
    @(posedge ref_clk) run <= 1'b0;
    @(posedge ref_clk) cfg <= '{g, cs, m[1], m[0]};
    @(posedge ref_clk) cw <= '{1'b1, 1'b0, lo};
    @(posedge ref_clk) cw <= '{1'b0, 1'b1, hi};
    @(posedge ref_clk) cw <= '0;
    @(posedge ref_clk) run <= 1'b1;
    #1;
  endtask
  // bounded wait for the count to move; t holds the edges it took
  task automatic step_wait();
    was = {hb, lb};
    t = 0;
    while ({hb, lb} === was && t < 40) begin
      @(posedge ref_clk);
      #1;
      t++;
    end
    if (t >= 40) begin
      chk("count step", 16'h0001, 16'h0000);
      report_and_stop();
    end
  endtask
  function automatic logic [15:0] exp_step(input logic m0, input logic [7:0] hi, lo);
    if (!m0) return {hi, lo} + 16'h0001;
    if (lo[4:0] == 5'h1F) return {hi + 8'h01, lo[7:5], 5'h00};
    return {hi, lo[7:5], lo[4:0] + 5'h01};
  endfunction

  initial begin
    #400000;
    chk("watchdog", 16'h0000, 16'h0001);
    report_and_stop();
  end
  initial begin
    {rst_b, run, trig, ack_e, split, a_ovf, a_hi, ack_a, ack_b, start} = '0;
    gate = 1'b1;
    cfg = '0;
    cw = '0;
    en = '0;
    sel = '0;
    falls = '0;
    k = $urandom(32'h7AD1);
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk) en <= '{1'b1, 1'b1, 1'b1};
    setup(1'b0, 1'b0, MODE_RELOAD, 8'hFF, 8'hFE);
    step_wait();
    chk("reload", 16'hFEFE, {hb, lb});
    chk("b flag", 16'h0001, tfb);
    chk("baud tick", 16'h0001, baud);
    cyc(1);
    chk("irq b", 16'h0001, irq_b);
    pulse(3);
    cyc(1);
    chk("b flag ack", 16'h0000, tfb);
    @(posedge ref_clk) en <= '{1'b1, 1'b1, 1'b0};
    step_wait();
    step_wait();
    cyc(2);
    chk("masked irq b", 16'h0000, irq_b);
    pulse(3);
    for (i = 0; i < 6; i++) begin
      h = $urandom;
      l = (i < 2) ? 8'hFF : 8'($urandom);
      setup(1'b0, 1'b0, i[0] ? MODE_13BIT : MODE_16BIT, l, h);
      step_wait();
      chk("count step", exp_step(i[0], h, l), {hb, lb});
      step_wait();
      chk("tick spacing", 16'd6, 16'(t));
    end
    @(posedge ref_clk) gate <= 1'b0;
    setup(1'b1, 1'b0, MODE_16BIT, 8'h00, 8'h00);
    cyc(30);
    chk("gated hold", 16'h0000, {hb, lb});
    chk("ext flag", 16'h0001, efb);
    @(posedge ref_clk) gate <= 1'b1;
    cyc(6);
    pulse(4);
    step_wait();
    chk("ext flag ack", 16'h0000, efb);
    @(posedge ref_clk) trig <= 1'b1;
    @(posedge ref_clk) gate <= 1'b0;
    cyc(8);
    chk("ext edge flag", 16'h0001, efb);
    pulse(4);
    cyc(8);
    chk("ext edge once", 16'h0000, efb);
    @(posedge ref_clk) gate <= 1'b1;
    l = 8'($urandom) & 8'h7F;
    setup(1'b0, 1'b1, MODE_16BIT, l, 8'h00);
    @(posedge ref_clk) begin
      falls <= 3'($urandom % 4 + 1);
      start <= 1'b1;
    end
    @(posedge ref_clk) start <= 1'b0;
    @(posedge ref_clk);
    for (k = 0; k < 200 && busy === 1'b1; k++) @(posedge ref_clk);
    if (busy === 1'b1) begin
      chk("pin model done", 16'h0000, 16'h0001);
      report_and_stop();
    end
    cyc(20);
    chk("falls counted", {8'h00, l + 8'(falls)}, {hb, lb});
    @(posedge ref_clk) en <= '{1'b1, 1'b1, 1'b1};
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk) sel <= i[2:0];
      for (k = 1; k < (1 << i); k++) pulse(0);
      cyc(1);
      chk("divider early", 16'h0000, tfa);
      pulse(0);
      cyc(1);
      chk("divider flag", 16'h0001, tfa);
      cyc(1);
      chk("irq a", 16'h0001, irq_a);
      pulse(2);
      cyc(1);
      chk("a flag ack", 16'h0000, tfa);
    end
    pulse(3);
    @(posedge ref_clk) begin
      split <= 1'b1;
      run <= 1'b0;
    end
    cyc(2);
    chk("lent run off", 16'h0000, hi_run);
    @(posedge ref_clk) run <= 1'b1;
    cyc(2);
    chk("lent run on", 16'h0001, hi_run);
    pulse(1);
    cyc(1);
    chk("lent flag", 16'h0001, tfb);
    pulse(3);
    // split mode: only halt or the gate pin low with gating set stops timer b
    @(posedge ref_clk) cfg <= '{1'b0, 1'b0, 1'b1, 1'b1};
    @(posedge ref_clk) cw <= '{1'b1, 1'b0, 8'hFF};
    @(posedge ref_clk) cw <= '{1'b0, 1'b1, 8'hFE};
    @(posedge ref_clk) cw <= '0;
    cyc(12);
    chk("halt hold", 16'hFEFF, {hb, lb});
    @(posedge ref_clk) cfg <= '{1'b0, 1'b0, 1'b1, 1'b0};
    step_wait();
    chk("split reload", 16'hFEFE, {hb, lb});
    chk("split baud", 16'h0001, baud);
    chk("b flag kept", 16'h0000, tfb);
    report_and_stop();
  end
endmodule
`default_nettype wire
